// >>> timer8_wavegen_regs_test.sv
// Self-checking bench for the 8-bit wave timer
`timescale 1ns/1ps
module timer8_wavegen_regs_test;
  reg clk, nrst, wr_en, rd_en;
  reg [7:0] addr, wdata, rv, v;
  reg [2:0] irq_ack, m;
  reg [1:0] w;
  wire [7:0] rdata;
  wire irq, irq_ovf, irq_cmp_a, irq_cmp_b, wave_out_a, wave_out_b, wave_en_a, wave_en_b;
  integer n_mismatch, checked, cyc, i, s;
  localparam int DIVS [8] = '{5, 1, 8, 32, 64, 128, 256, 1024};
  localparam [7:0] RA [8] = '{8'h70, 8'h37, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'h00};
  tmr8_wavegen u_tmr8_wavegen (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .irq_ack(irq_ack), .irq(irq), .irq_ovf(irq_ovf), .irq_cmp_a(irq_cmp_a),
    .irq_cmp_b(irq_cmp_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_en_a(wave_en_a),
    .wave_en_b(wave_en_b));
  // Force strobes only act outside the PWM modes
  function fa(input [2:0] md);
    fa = !md[0];
  endfunction
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      rv = rdata;
    end
  endtask
  task ck(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task test_done;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang is cut short well beyond the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  initial begin
    {nrst, wr_en, rd_en, addr, wdata, irq_ack} = 0;
    {n_mismatch, checked, cyc} = 0;
    s = $urandom(75);
    wt(4);
    nrst <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd(RA[i]);
      ck(rv, 8'h00);
    end
    for (i = 0; i < 8; i = i + 1) begin
      v = $urandom;
      wr(8'hb3, v);
      wr(8'hb4, ~v);
      wr(8'h70, v);
      wr(8'hb2, v);
      rd(8'hb3);
      ck(rv, v);
      rd(8'hb4);
      ck(rv, ~v);
      rd(8'h70);
      ck(rv, v & 8'h07);
      wt(5);
      rd(8'hb2);
      ck(rv, v);
    end
    wr(8'hb1, 8'hc8);
    rd(8'hb1);
    ck(rv, 8'h08);
    // Two reads exactly two tick periods apart differ by two, or by zero with the clock stopped
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'hb1, i);
      rd(8'hb2);
      v = rv;
      wt(2 * DIVS[i] - 2);
      rd(8'hb2);
      ck(rv - v, (i == 0) ? 8'h00 : 8'h02);
    end
    wr(8'hb1, 8'h00);
    wr(8'h37, 8'h07);
    rd(8'hb2);
    v = rv;
    for (i = 0; i < 8; i = i + 1) begin
      m = i;
      wr(8'hb0, {6'h14, m[1:0]});
      wr(8'hb1, {4'h0, m[2], 3'h0});
      wt(2);
      w = {wave_out_a, wave_out_b};
      wr(8'hb1, {fa(m) ? 4'hc : 4'h0, m[2], 3'h0});
      wt(2);
      ck({6'h00, wave_out_a, wave_out_b}, {6'h00, fa(m) ? ~w : w});
    end
    ck({7'h00, wave_en_a}, 8'h01);
    rd(8'h37);
    ck(rv, 8'h00);
    rd(8'hb2);
    ck(rv, v);
    wr(8'hb1, 8'h00);
    wr(8'hb0, 8'hf0);
    wr(8'hb1, 8'hc0);
    wt(2);
    ck({6'h00, wave_out_a, wave_out_b}, 8'h03);
    wr(8'hb0, 8'ha0);
    wr(8'hb1, 8'hc0);
    wt(2);
    ck({6'h00, wave_out_a, wave_out_b}, 8'h00);
    wr(8'hb0, 8'h00);
    wt(3);
    ck({6'h00, wave_en_a, wave_en_b}, 8'h00);
    // Matches raise flags and, once enabled, interrupt lines
    wr(8'hb8, 8'h01);
    wr(8'h70, 8'h07);
    v = $urandom;
    wr(8'hb3, v);
    wr(8'hb4, v + 8'd40);
    wr(8'hb2, v - 8'd20);
    wr(8'hb1, 8'h01);
    i = 0;
    while (irq_cmp_a !== 1'b1 && i < 100) begin
      @(posedge clk);
      #1;
      i = i + 1;
    end
    ck({6'h00, i < 100, irq_cmp_b}, 8'h02);
    wt(40);
    wr(8'hb1, 8'h00);
    ck({6'h00, irq_cmp_b, irq}, 8'h03);
    wr(8'h37, 8'h02);
    wt(2);
    ck({6'h00, irq_cmp_a, irq_cmp_b}, 8'h01);
    @(posedge clk);
    irq_ack <= 3'h4;
    @(posedge clk);
    irq_ack <= 3'h0;
    wt(2);
    ck({7'h00, irq_cmp_b}, 8'h00);
    wr(8'h70, 8'h06);
    wr(8'hb2, 8'hfe);
    wr(8'hb1, 8'h01);
    wt(5);
    wr(8'hb1, 8'h00);
    rd(8'h37);
    ck({6'h00, rv[0], irq_ovf}, 8'h02);
    wr(8'h70, 8'h01);
    wt(3);
    ck({7'h00, irq_ovf}, 8'h01);
    wr(8'hb8, 8'h00);
    wt(3);
    ck({7'h00, irq}, 8'h00);
    // A counter write hides the match on the following tick
    wr(8'h37, 8'h07);
    wr(8'hb3, 8'h10);
    wr(8'hb2, 8'h10);
    wr(8'hb1, 8'h01);
    wt(6);
    rd(8'h37);
    ck({7'h00, rv[1]}, 8'h00);
    wt(300);
    rd(8'h37);
    ck({7'h00, rv[1]}, 8'h01);
    test_done;
  end
endmodule

// >>> tmr8_consts.vh
// Register offsets, field positions, reset values, counter limits, mode and action codes for the 8-bit wave timer
`ifndef TMR8_CONSTS_VH
`define TMR8_CONSTS_VH
`define TMR8_ADDR_W 8
`define TMR8_OFF_IRQ_MASK 8'h70
`define TMR8_OFF_IRQ_FLAGS 8'h37
`define TMR8_OFF_CTRL_A 8'hb0
`define TMR8_OFF_CTRL_B 8'hb1
`define TMR8_OFF_COUNT 8'hb2
`define TMR8_OFF_CMP_A 8'hb3
`define TMR8_OFF_CMP_B 8'hb4
`define TMR8_OFF_GIE 8'hb8
`define TMR8_RST_VAL 8'h00
`define TMR8_BIT_FORCE_A 7
`define TMR8_BIT_FORCE_B 6
`define TMR8_BIT_MODE_HI 3
`define TMR8_BIT_OVF 0
`define TMR8_BIT_CMP_A 1
`define TMR8_BIT_CMP_B 2
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`define TMR8_MODE_NORMAL 3'h0
`define TMR8_MODE_PC_FF 3'h1
`define TMR8_MODE_CTC 3'h2
`define TMR8_MODE_FAST_FF 3'h3
`define TMR8_MODE_PC_A 3'h5
`define TMR8_MODE_FAST_A 3'h7
`define TMR8_ACT_OFF 2'h0
`define TMR8_ACT_TOGGLE 2'h1
`define TMR8_ACT_CLEAR 2'h2
`define TMR8_ACT_SET 2'h3
`define TMR8_PS_W 10
`endif

// >>> tmr8_wavegen.v
// 8-bit timer/counter with two compare channels, waveform generation and a register port
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "tmr8_consts.vh"

module tmr8_wavegen #(
  parameter ADDR_W = `TMR8_ADDR_W
) (
  input wire clk,
  input wire nrst,
  input wire [ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire [2:0] irq_ack,
  output reg irq,
  output reg irq_ovf,
  output reg irq_cmp_a,
  output reg irq_cmp_b,
  output reg wave_out_a,
  output reg wave_out_b,
  output reg wave_en_a,
  output reg wave_en_b
);

  // Register map, byte offsets on addr:
  //   irq_mask    bit 0 overflow, bit 1 compare A, bit 2 compare B enables
  //   irq_flags   same layout, sticky, cleared by writing one or by irq_ack
  //   ctrl_a      out_action_a [7:6], out_action_b [5:4], low mode bits [1:0]
  //   ctrl_b      force_match_a [7], force_match_b [6], wave_mode_hi [3], clk_sel [2:0]
  //   count_value, compare_a_value, compare_b_value are plain 8-bit values
  //   global enable bit 0 stands in for the processor's interrupt enable
  // Unmapped offsets read zero and ignore writes.
  // Read data come one cycle after the strobe; the port never stalls.

  // Software-visible registers, plus the hidden compare buffers ocr_a_buf_reg and ocr_b_buf_reg
  reg [7:0] count_value_reg;
  reg [7:0] compare_a_value_reg;
  reg [7:0] compare_b_value_reg;
  reg [7:0] ocr_a_buf_reg;
  reg [7:0] ocr_b_buf_reg;
  reg [2:0] irq_mask_reg;
  reg [2:0] irq_flags_reg;
  reg [1:0] out_action_a_reg;
  reg [1:0] out_action_b_reg;
  reg [1:0] wave_mode_lo_reg;
  reg wave_mode_hi_reg;
  reg [2:0] clk_sel_reg;
  reg gie_reg;
  // Internal counting state: direction, match block, prescaler history and wave levels
  reg down_reg;
  reg block_reg;
  reg [`TMR8_PS_W-1:0] ps_reg;
  reg [`TMR8_PS_W-1:0] ps_prev_reg;
  reg out_a_reg;
  reg out_b_reg;

  // Decode and next-state values; apart from wave_mode_sel, all produced by the combinational processes below
  wire [2:0] wave_mode_sel = {wave_mode_hi_reg, wave_mode_lo_reg};
  reg [2:0] mode_eff;
  reg tick;
  reg [7:0] top;
  reg is_pwm;
  reg is_fast;
  reg is_pc;
  reg [7:0] cnt_next;
  reg down_next;
  reg ovf_ev;
  reg hit_a;
  reg hit_b;
  reg upd_ocr;
  reg out_a_next;
  reg out_b_next;
  reg [7:0] rd_next;
  reg [2:0] flags_next;

  // Write decodes; force strobes are qualified by the mode held in the write cycle,
  // so a write that changes the mode and forces at once uses the old mode
  wire wr_ctrl_b = wr_en && (addr == `TMR8_OFF_CTRL_B);
  wire wr_cnt = wr_en && (addr == `TMR8_OFF_COUNT);
  wire force_a = wr_ctrl_b && wdata[`TMR8_BIT_FORCE_A] && !is_pwm;
  wire force_b = wr_ctrl_b && wdata[`TMR8_BIT_FORCE_B] && !is_pwm;

  // Function of one output-action code on a non-PWM match
  // Code 00 keeps the internal level; the pin itself is released by wave_en
  // Used for real and forced matches alike, so both follow the same table
  function act_apply;
    input [1:0] act;
    input cur;
    begin
      case (act)
        `TMR8_ACT_TOGGLE: act_apply = ~cur;
        `TMR8_ACT_CLEAR: act_apply = 1'b0;
        `TMR8_ACT_SET: act_apply = 1'b1;
        default: act_apply = cur;
      endcase
    end
  endfunction

  // Mode decode; reserved codes fall back to normal counting
  // TOP reads the compare A register itself: in clear-on-match the update is
  // immediate, and in the PWM modes software is expected to change it only
  // once per period, so no separate TOP buffer is kept
  // Reserved codes map to normal so flags and outputs stay deterministic
  always @* begin
    case (wave_mode_sel)
      `TMR8_MODE_PC_FF, `TMR8_MODE_CTC, `TMR8_MODE_FAST_FF, `TMR8_MODE_PC_A, `TMR8_MODE_FAST_A: begin
        mode_eff = wave_mode_sel;
      end
      default: begin
        mode_eff = `TMR8_MODE_NORMAL;
      end
    endcase
    top = `TMR8_MAX;
    if (mode_eff == `TMR8_MODE_CTC || mode_eff == `TMR8_MODE_PC_A || mode_eff == `TMR8_MODE_FAST_A) begin
      top = compare_a_value_reg;
    end
    is_fast = (mode_eff == `TMR8_MODE_FAST_FF) || (mode_eff == `TMR8_MODE_FAST_A);
    is_pc = (mode_eff == `TMR8_MODE_PC_FF) || (mode_eff == `TMR8_MODE_PC_A);
    is_pwm = is_fast || is_pc;
  end

  // Prescaler bit whose falling edge gives each divided rate
  localparam TAP_DIV8 = 2;
  localparam TAP_DIV32 = 4;
  localparam TAP_DIV64 = 5;
  localparam TAP_DIV128 = 6;
  localparam TAP_DIV256 = 7;
  localparam TAP_DIV1024 = 9;

  // Prescaler tap select; a tap fires on the falling edge of its counter bit
  // The prescaler is only reset by nrst, so the first tick after a new selection may
  // come early; software that needs exact phase must allow for one short period
  always @* begin
    case (clk_sel_reg)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = ps_prev_reg[TAP_DIV8] & ~ps_reg[TAP_DIV8];
      3'h3: tick = ps_prev_reg[TAP_DIV32] & ~ps_reg[TAP_DIV32];
      3'h4: tick = ps_prev_reg[TAP_DIV64] & ~ps_reg[TAP_DIV64];
      3'h5: tick = ps_prev_reg[TAP_DIV128] & ~ps_reg[TAP_DIV128];
      3'h6: tick = ps_prev_reg[TAP_DIV256] & ~ps_reg[TAP_DIV256];
      default: tick = ps_prev_reg[TAP_DIV1024] & ~ps_reg[TAP_DIV1024];
    endcase
  end

  // Counter step, matches and waveform next state
  // Phase correct counts up to TOP, turns, and counts down to BOTTOM, where the
  // overflow event is raised; the other modes wrap from TOP to BOTTOM
  // A software count write overrides the step taken in the same cycle
  always @* begin
    cnt_next = count_value_reg;
    down_next = down_reg;
    ovf_ev = 1'b0;
    upd_ocr = 1'b0;
    // Matches use the value the counter holds during this timer clock
    // Comparing before the step means a match is seen one tick after the
    // counter reaches the compare value, as it is for the overflow event
    hit_a = tick && !block_reg && (count_value_reg == ocr_a_buf_reg);
    hit_b = tick && !block_reg && (count_value_reg == ocr_b_buf_reg);
    out_a_next = out_a_reg;
    out_b_next = out_b_reg;
    if (tick) begin
      if (is_pc) begin
        if (!down_reg) begin
          if (count_value_reg == top) begin
            down_next = 1'b1;
            cnt_next = count_value_reg - 8'h01;
            upd_ocr = 1'b1;
          end else begin
            cnt_next = count_value_reg + 8'h01;
          end
        end else if (count_value_reg == `TMR8_BOTTOM) begin
          down_next = 1'b0;
          cnt_next = count_value_reg + 8'h01;
          ovf_ev = 1'b1;
        end else begin
          cnt_next = count_value_reg - 8'h01;
        end
      end else if (count_value_reg == top) begin
        cnt_next = `TMR8_BOTTOM;
        down_next = 1'b0;
        ovf_ev = (mode_eff != `TMR8_MODE_CTC) || (top == `TMR8_MAX);
        upd_ocr = is_fast;
      end else begin
        cnt_next = count_value_reg + 8'h01;
      end
    end
    if (wr_cnt) begin
      cnt_next = wdata;
    end
    // Output action per mode class
    if (!is_pwm) begin
      if (hit_a || force_a) out_a_next = act_apply(out_action_a_reg, out_a_reg);
      if (hit_b || force_b) out_b_next = act_apply(out_action_b_reg, out_b_reg);
    end else begin
      // PWM: code 01 toggles channel A only when compare A serves as TOP
      // Codes 1x set or clear on match, inverted while phase correct counts down
      // Channel B has no toggle form; its code 01 leaves the level alone
      // The equal-to-TOP special case is not modelled separately
      if (hit_a && out_action_a_reg == `TMR8_ACT_TOGGLE && wave_mode_hi_reg) out_a_next = ~out_a_reg;
      if (hit_a && out_action_a_reg[1]) out_a_next = out_action_a_reg[0] ^ (is_pc & down_reg);
      if (hit_b && out_action_b_reg[1]) out_b_next = out_action_b_reg[0] ^ (is_pc & down_reg);
      // Fast PWM restores the opposite level as the counter wraps to BOTTOM,
      // which takes priority over a match seen in the same tick
      if (tick && is_fast && count_value_reg == top) begin
        if (out_action_a_reg[1]) out_a_next = ~out_action_a_reg[0];
        if (out_action_b_reg[1]) out_b_next = ~out_action_b_reg[0];
      end
    end
  end

  // Flags: a hardware event wins over a clear in the same cycle; forced matches never set them
  // Losing the clear is harmless: software sees the flag again and acknowledges it,
  // whereas losing the event would drop an interrupt for good
  always @* begin
    flags_next = irq_flags_reg & ~irq_ack;
    if (wr_en && addr == `TMR8_OFF_IRQ_FLAGS) begin
      flags_next = flags_next & ~wdata[2:0];
    end
    if (ovf_ev) flags_next[`TMR8_BIT_OVF] = 1'b1;
    if (hit_a) flags_next[`TMR8_BIT_CMP_A] = 1'b1;
    if (hit_b) flags_next[`TMR8_BIT_CMP_B] = 1'b1;
  end

  // Read mux; unmapped offsets read zero
  // Force strobes are never stored, so ctrl_b shows zeros in bits 7 and 6
  // The count reads the live counter; a read during counting sees the pre-step value
  always @* begin
    case (addr)
      `TMR8_OFF_IRQ_MASK: rd_next = {5'h00, irq_mask_reg};
      `TMR8_OFF_IRQ_FLAGS: rd_next = {5'h00, irq_flags_reg};
      `TMR8_OFF_CTRL_A: rd_next = {out_action_a_reg, out_action_b_reg, 2'h0, wave_mode_lo_reg};
      `TMR8_OFF_CTRL_B: rd_next = {2'h0, 2'h0, wave_mode_hi_reg, clk_sel_reg};
      `TMR8_OFF_COUNT: rd_next = count_value_reg;
      `TMR8_OFF_CMP_A: rd_next = compare_a_value_reg;
      `TMR8_OFF_CMP_B: rd_next = compare_b_value_reg;
      `TMR8_OFF_GIE: rd_next = {7'h00, gie_reg};
      default: rd_next = 8'h00;
    endcase
  end

  // Register file, counter and waveform state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_value_reg <= `TMR8_RST_VAL;
      compare_a_value_reg <= `TMR8_RST_VAL;
      compare_b_value_reg <= `TMR8_RST_VAL;
      ocr_a_buf_reg <= `TMR8_RST_VAL;
      ocr_b_buf_reg <= `TMR8_RST_VAL;
      irq_mask_reg <= 3'h0;
      irq_flags_reg <= 3'h0;
      out_action_a_reg <= 2'h0;
      out_action_b_reg <= 2'h0;
      wave_mode_lo_reg <= 2'h0;
      wave_mode_hi_reg <= 1'b0;
      clk_sel_reg <= 3'h0;
      gie_reg <= 1'b0;
      down_reg <= 1'b0;
      block_reg <= 1'b0;
      ps_reg <= {`TMR8_PS_W{1'b0}};
      ps_prev_reg <= {`TMR8_PS_W{1'b0}};
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
    end else begin
      // Free-running prescaler; shared taps keep all divided rates phase aligned
      ps_reg <= ps_reg + {{(`TMR8_PS_W-1){1'b0}}, 1'b1};
      ps_prev_reg <= ps_reg;
      count_value_reg <= cnt_next;
      down_reg <= down_next;
      // Block stays armed until the next timer clock has passed
      // A write while stopped keeps the block until counting resumes, so the
      // first tick after a start never matches on the written value
      if (wr_cnt) begin
        block_reg <= 1'b1;
      end else if (tick) begin
        block_reg <= 1'b0;
      end
      irq_flags_reg <= flags_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      // Compare buffers follow at once outside PWM, else at the mode's update point
      // Buffering in PWM avoids glitches when software changes a duty mid-period
      if (!is_pwm || upd_ocr) begin
        ocr_a_buf_reg <= compare_a_value_reg;
        ocr_b_buf_reg <= compare_b_value_reg;
      end
      if (wr_en) begin
        case (addr)
          // Mask keeps only its three enable bits
          `TMR8_OFF_IRQ_MASK: irq_mask_reg <= wdata[2:0];
          `TMR8_OFF_CTRL_A: begin
            out_action_a_reg <= wdata[7:6];
            out_action_b_reg <= wdata[5:4];
            wave_mode_lo_reg <= wdata[1:0];
          end
          // Force bits act as strobes above and are not stored here
          `TMR8_OFF_CTRL_B: begin
            wave_mode_hi_reg <= wdata[`TMR8_BIT_MODE_HI];
            clk_sel_reg <= wdata[2:0];
          end
          // Compare values land here; the match logic reads the buffered copies
          `TMR8_OFF_CMP_A: compare_a_value_reg <= wdata;
          `TMR8_OFF_CMP_B: compare_b_value_reg <= wdata;
          `TMR8_OFF_GIE: gie_reg <= wdata[0];
          default: begin
          end
        endcase
      end
    end
  end

  // Registered outputs, kept apart from the register file so every pin
  // comes straight from a flip-flop and sees one cycle of delay
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      irq <= 1'b0;
      irq_ovf <= 1'b0;
      irq_cmp_a <= 1'b0;
      irq_cmp_b <= 1'b0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
      wave_en_a <= 1'b0;
      wave_en_b <= 1'b0;
    end else begin
      // Read data stand one cycle, then return to zero
      rdata <= rd_ctrl(rd_en, rd_next);
      // Each request needs its mask bit, the global enable and its flag
      irq_ovf <= gie_reg && irq_mask_reg[`TMR8_BIT_OVF] && irq_flags_reg[`TMR8_BIT_OVF];
      irq_cmp_a <= gie_reg && irq_mask_reg[`TMR8_BIT_CMP_A] && irq_flags_reg[`TMR8_BIT_CMP_A];
      irq_cmp_b <= gie_reg && irq_mask_reg[`TMR8_BIT_CMP_B] && irq_flags_reg[`TMR8_BIT_CMP_B];
      // Summary line, high while any enabled flag is set
      irq <= gie_reg && |(irq_mask_reg & irq_flags_reg);
      // A disconnected channel drives low and drops its enable
      wave_out_a <= out_a_reg & (out_action_a_reg != `TMR8_ACT_OFF);
      wave_out_b <= out_b_reg & (out_action_b_reg != `TMR8_ACT_OFF);
      wave_en_a <= (out_action_a_reg != `TMR8_ACT_OFF);
      wave_en_b <= (out_action_b_reg != `TMR8_ACT_OFF);
    end
  end

  // Read data stand only in the cycle after the strobe
  // Zero outside that cycle keeps a shared read bus free of stale values
  function [7:0] rd_ctrl;
    input en;
    input [7:0] val;
    begin
      rd_ctrl = en ? val : 8'h00;
    end
  endfunction

endmodule

// >>> tmr8_wavegen_monitor.sv
// Concurrent checks on the register port, interrupt and wave outputs of the wave timer
`timescale 1ns/1ps
module tmr8_wavegen_monitor #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire nrst,
  input wire [ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  input wire [2:0] irq_ack,
  input wire irq,
  input wire irq_ovf,
  input wire irq_cmp_a,
  input wire irq_cmp_b,
  input wire wave_out_a,
  input wire wave_out_b,
  input wire wave_en_a,
  input wire wave_en_b
);
  reg [2:0] mask_q;
  reg gie_q;
  reg [7:0] cmpa_q;
  // Shadow of settings, so outputs can be tied to what software wrote
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= 3'h0;
      gie_q <= 1'b0;
      cmpa_q <= 8'h00;
    end else if (wr_en) begin
      if (addr == 8'h70) mask_q <= wdata[2:0];
      if (addr == 8'hb8) gie_q <= wdata[0];
      if (addr == 8'hb3) cmpa_q <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RDATA_IDLE: assert property (rdata != 8'h00 |-> $past(rd_en))
    else $error("read data outside read answer cycle");
  AST_FORCE_RD_ZERO: assert property ($past(rd_en) && $past(addr) == 8'hb1 |-> rdata[7:6] == 2'b00)
    else $error("force bits read as one");
  AST_IRQ_OR: assert property (irq == (irq_ovf | irq_cmp_a | irq_cmp_b))
    else $error("summary interrupt differs from sources");
  AST_CMPB_MASK: assert property (irq_cmp_b |-> $past(mask_q[2]) && $past(gie_q))
    else $error("compare B interrupt without enable");
  AST_CMPA_MASK: assert property (irq_cmp_a |-> $past(mask_q[1]) && $past(gie_q))
    else $error("compare A interrupt without enable");
  AST_OVF_MASK: assert property (irq_ovf |-> $past(mask_q[0]) && $past(gie_q))
    else $error("overflow interrupt without enable");
  AST_CMPA_RD: assert property ($past(rd_en) && $past(addr) == 8'hb3 |-> rdata == $past(cmpa_q))
    else $error("compare A readback wrong");
  AST_MASK_RD: assert property ($past(rd_en) && $past(addr) == 8'h70 |-> rdata == {5'h00, $past(mask_q)})
    else $error("mask readback wrong");
  AST_WAVE_OFF: assert property ($fell(wave_en_a) |-> ##[0:2] !wave_out_a)
    else $error("wave output stays high when disconnected");
  COV_CMPA: cover property ($rose(irq_cmp_a));
  COV_OVF: cover property ($rose(irq_ovf));
  COV_WAVE: cover property ($rose(wave_out_a));
endmodule
bind tmr8_wavegen tmr8_wavegen_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk(clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq_ack(irq_ack), .irq(irq),
  .irq_ovf(irq_ovf), .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b), .wave_out_a(wave_out_a),
  .wave_out_b(wave_out_b), .wave_en_a(wave_en_a), .wave_en_b(wave_en_b));
